/* File: core/acm_pkg.sv */
// Constants, types and register map of the converter calibration block.
package acm_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_RESULT = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_CONFIG = 4'h8;
  localparam logic [3:0] IDX_OFFSET = 4'h9;
  localparam logic [3:0] IDX_GAIN   = 4'ha;

  // Fields of the third configuration word, low bits first from mode.
  typedef struct packed {
    logic       scan;
    logic [1:0] state;
    logic       gain_en;
    logic       off_en;
    logic [1:0] mode;
  } acm_cfg_t;

  // Reset values.
  localparam logic [6:0]  CFG_RST    = 7'h00;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST   = 24'h800000;

  // Converter-state codes.
  localparam logic [1:0] ST_SHUTDOWN = 2'h0;
  localparam logic [1:0] ST_STANDBY  = 2'h2;
  localparam logic [1:0] ST_CONVERT  = 2'h3;

  // Timing counts, in system clocks or decimation clock periods, and the scan length in conversions.
  localparam logic [1:0] DECIMATION_CLOCK_DIV     = 2'h3;
  localparam logic [8:0] STARTUP_DECIMATION_CLOCK = 9'h100;
  localparam logic [4:0] GCAL_DECIMATION_CLOCK    = 5'h17;
  localparam logic [2:0] SCAN_LEN      = 3'h4;
  localparam logic [7:0] CYCLE_GAP     = 8'h10;

  // Output full-scale codes.
  localparam logic [23:0] FS_POS = 24'h7fffff;
  localparam logic [23:0] FS_NEG = 24'h800000;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CONV = 3'b010,
    S_GAP  = 3'b100
  } acm_state_t;

  // Saturates a wide signed value to 24 bits; the top bit flags overload.
  function automatic logic [24:0] sat24(input logic signed [48:0] v);
    logic signed [48:0] hi;
    logic signed [48:0] lo;
    hi = $signed({25'h0000000, FS_POS});
    lo = $signed({{25{1'b1}}, FS_NEG});
    if (v > hi)
      sat24 = {1'b1, FS_POS};
    else if (v < lo)
      sat24 = {1'b1, FS_NEG};
    else
      sat24 = {1'b0, v[23:0]};
  endfunction

endpackage

/* File: core/acm_core.sv */
// What this block does
// - Add offset to each raw code when enabled.
// - Multiply code by gain when enabled.
// - Disabled correction is skipped, its register ignored.
// - Output is raw plus offset, times gain.
// - Overload judged only on the final product.
// - Offset register is 24-bit signed two's complement.
// - Offset LSB equals one output code LSB.
// - Offset adder adds no cycles.
// - Offset enable affects only the next result.
// - New offset value used from next result.
// - Gain code over 8388608 gives multiplier.
// - Gain multiply takes 23 decimation periods.
// - Gain latency never delays the next conversion.
// - Gain enable affects only the next result.
// - New gain value used from next result.
// - Two-bit mode, meaning differs single versus scan.
// - Mode 0x: one run, then shutdown, state 0x.
// - Mode 10: one run, then standby, state 10.
// - Mode 11: continuous, scan cycles spaced by gap.
// - In shutdown the start-up timer holds 256.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module acm_core
  import acm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_code,
  output logic             conv_start,
  output logic             data_ready,
  output logic             overload
);

  acm_cfg_t           cfg_q;
  acm_cfg_t           cfg_d;
  logic [23:0]        off_q;
  logic [23:0]        gain_q;
  logic [23:0]        result_q;
  logic               ovf_q;
  logic               drdy_q;
  logic               start_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [31:0]        prdata_q;
  logic [1:0]         div_q;
  logic               tick_q;
  logic [8:0]         tmr_q;
  acm_state_t         st_q;
  acm_state_t         st_d;
  logic [2:0]         cnt_q;
  logic [2:0]         cnt_d;
  logic [7:0]         gap_q;
  logic [7:0]         gap_d;
  logic               start_d;
  logic               hw_wr;
  logic [1:0]         hw_val;
  logic signed [24:0] mcand_q;
  logic [23:0]        mplier_q;
  logic signed [48:0] acc_q;
  logic [4:0]         mcnt_q;
  logic               mbusy_q;
  // Bus decode.
  wire       setup_w  = psel & penable & ~pready_q;
  wire       access_w = psel & penable & pready_q;
  wire [3:0] idx_w    = paddr[5:2];
  wire       align_w  = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
  wire       hit_res  = align_w && (idx_w == IDX_RESULT);
  wire       hit_sts  = align_w && (idx_w == IDX_STATUS);
  wire       hit_cfg  = align_w && (idx_w == IDX_CONFIG);
  wire       hit_off  = align_w && (idx_w == IDX_OFFSET);
  wire       hit_gain = align_w && (idx_w == IDX_GAIN);
  wire       map_ok   = hit_res | hit_sts | hit_cfg | hit_off | hit_gain;
  wire       wr_w     = access_w & pwrite;
  wire [31:0] status_w = {15'h0000, tmr_q, 6'h00, mbusy_q, ovf_q};
  wire [31:0] rd_w =
    hit_res  ? {8'h00, result_q} :
    hit_sts  ? status_w :
    hit_cfg  ? {25'h0000000, cfg_q} :
    hit_off  ? {8'h00, off_q} :
    hit_gain ? {8'h00, gain_q} : 32'h00000000;
  // Correction datapath.
  wire signed [24:0] raw_w  = $signed({raw_code[23], raw_code});
  wire signed [24:0] offt_w = cfg_q.off_en ?
    $signed({off_q[23], off_q}) : 25'sh0000000;
  wire signed [24:0] sum_w  = raw_w + offt_w;
  wire signed [48:0] sumx_w = $signed({{24{sum_w[24]}}, sum_w});
  wire [24:0]        dsat_w = sat24(sumx_w);
  wire signed [48:0] mcx_w  = $signed({{24{mcand_q[24]}}, mcand_q});
  wire signed [48:0] part_w = mplier_q[mcnt_q] ?
    (mcx_w <<< mcnt_q) : 49'sh0;
  wire signed [48:0] accn_w = acc_q + part_w;
  wire [24:0]        msat_w = sat24(accn_w >>> 23);
  wire               mdone_w = mbusy_q && tick_q &&
    (mcnt_q == GCAL_DECIMATION_CLOCK - 5'h01);
  wire               direct_w = raw_valid && !cfg_q.gain_en;
  wire               start_ok = (cfg_q.state == ST_CONVERT) &&
    (tmr_q == 9'h000);
  // Bus slave: one wait state, then the answer with pready.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~map_ok;
      prdata_q  <= (setup_w & ~pwrite) ? rd_w : 32'h00000000;
    end
  end

  // Hardware rewrite of the state field wins over a software write.
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_w && hit_cfg)
      cfg_d = acm_cfg_t'(pwdata[6:0]);
    if (hw_wr)
      cfg_d.state = hw_val;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q  <= acm_cfg_t'(CFG_RST);
      off_q  <= OFFSET_RST;
      gain_q <= GAIN_RST;
    end
    else
    begin
      cfg_q <= cfg_d;
      if (wr_w && hit_off)
        off_q <= pwdata[23:0];
      if (wr_w && hit_gain)
        gain_q <= pwdata[23:0];
    end
  end
  // Decimation clock enable and start-up timer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
      tmr_q  <= STARTUP_DECIMATION_CLOCK;
    end
    else
    begin
      div_q  <= (div_q == DECIMATION_CLOCK_DIV) ? 2'h0 : div_q + 2'h1;
      tick_q <= (div_q == DECIMATION_CLOCK_DIV);
      if (!cfg_q.state[1])
        tmr_q <= STARTUP_DECIMATION_CLOCK;
      else if (tick_q && tmr_q != 9'h000)
        tmr_q <= tmr_q - 9'h001;
    end
  end

  // Conversion sequencer; the multiplier never holds it back.
  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    gap_d   = gap_q;
    start_d = 1'b0;
    hw_wr   = 1'b0;
    hw_val  = cfg_q.state;
    case (st_q)
      S_IDLE:
      begin
        cnt_d = 3'h0;
        if (start_ok)
        begin
          start_d = 1'b1;
          st_d    = S_CONV;
        end
      end
      S_CONV:
      begin
        if (raw_valid)
        begin
          if (cfg_q.scan && cnt_q != SCAN_LEN - 3'h1)
          begin
            cnt_d   = cnt_q + 3'h1;
            start_d = 1'b1;
          end
          else
          begin
            cnt_d = 3'h0;
            if (cfg_q.mode == ST_CONVERT)
            begin
              if (cfg_q.state != ST_CONVERT)
                st_d = S_IDLE;
              else if (cfg_q.scan)
              begin
                gap_d = 8'h00;
                st_d  = S_GAP;
              end
              else
                start_d = 1'b1;
            end
            else
            begin
              hw_wr  = 1'b1;
              hw_val = cfg_q.mode[1] ? ST_STANDBY : ST_SHUTDOWN;
              st_d   = S_IDLE;
            end
          end
        end
      end
      S_GAP:
      begin
        if (cfg_q.state != ST_CONVERT)
          st_d = S_IDLE;
        else if (tick_q)
        begin
          gap_d = gap_q + 8'h01;
          if (gap_q == CYCLE_GAP - 8'h01)
          begin
            start_d = 1'b1;
            st_d    = S_CONV;
          end
        end
      end
      default:
        st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= S_IDLE;
      cnt_q   <= 3'h0;
      gap_q   <= 8'h00;
      start_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      gap_q   <= gap_d;
      start_q <= start_d;
    end
  end
  // Serial add-and-shift gain multiplier; settings captured per result.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcand_q  <= 25'sh0000000;
      mplier_q <= 24'h000000;
      acc_q    <= 49'sh0;
      mcnt_q   <= 5'h00;
      mbusy_q  <= 1'b0;
    end
    else if (raw_valid && cfg_q.gain_en)
    begin
      mcand_q  <= sum_w;
      mplier_q <= gain_q;
      acc_q    <= gain_q[23] ? (sumx_w <<< 23) : 49'sh0;
      mcnt_q   <= 5'h00;
      mbusy_q  <= 1'b1;
    end
    else if (mbusy_q && tick_q)
    begin
      acc_q   <= accn_w;
      mcnt_q  <= mcnt_q + 5'h01;
      mbusy_q <= !mdone_w;
    end
  end

  // Result register changes only together with the data-ready pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= 24'h000000;
      ovf_q    <= 1'b0;
      drdy_q   <= 1'b0;
    end
    else
    begin
      drdy_q <= mdone_w | direct_w;
      if (mdone_w)
      begin
        result_q <= msat_w[23:0];
        ovf_q    <= msat_w[24];
      end
      else if (direct_w)
      begin
        result_q <= dsat_w[23:0];
        ovf_q    <= dsat_w[24];
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign conv_start = start_q;
  assign data_ready = drdy_q;
  assign overload   = ovf_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_direct_cap;
    raw_valid && !cfg_q.gain_en && !mdone_w;
  endsequence
  sequence s_last_done;
    st_q == S_CONV && raw_valid &&
      (!cfg_q.scan || cnt_q == SCAN_LEN - 3'h1);
  endsequence
  offset_result_a: assert property (
    s_direct_cap |=> drdy_q &&
      ($signed(result_q) == $past(sum_w) || ovf_q))
    else $error("Direct result does not match raw plus offset.");
  offset_skip_a: assert property (
    s_direct_cap ##0 !cfg_q.off_en |=>
      $signed(result_q) == $past(raw_w) || ovf_q)
    else $error("Disabled offset still changed the result.");
  result_hold_a: assert property (
    !drdy_q |-> $stable(result_q))
    else $error("Result changed without a data-ready pulse.");
  gain_latency_a: assert property (
    raw_valid && cfg_q.gain_en && !mbusy_q |=>
      (mbusy_q && !drdy_q) [*8])
    else $error("Gain result delivered too early.");
  gain_done_a: assert property (
    mdone_w |=> drdy_q && !mbusy_q && result_q == $past(msat_w[23:0]))
    else $error("Gain result not delivered at end of multiply.");
  shutdown_tmr_a: assert property (
    !cfg_q.state[1] |=> tmr_q == STARTUP_DECIMATION_CLOCK)
    else $error("Start-up timer not held in shutdown.");
  oneshot_end_a: assert property (
    s_last_done ##0 !cfg_q.mode[1] |=>
      cfg_q.state == ST_SHUTDOWN && st_q == S_IDLE)
    else $error("One-shot run did not return to shutdown.");
  standby_end_a: assert property (
    s_last_done ##0 cfg_q.mode == ST_STANDBY |=>
      cfg_q.state == ST_STANDBY && st_q == S_IDLE)
    else $error("One-shot run did not return to standby.");
  continuous_a: assert property (
    s_last_done ##0 cfg_q.mode == ST_CONVERT &&
      cfg_q.state == ST_CONVERT && !cfg_q.scan |=>
      start_q && cfg_q.state == ST_CONVERT)
    else $error("Continuous mode did not restart at once.");
  start_gate_a: assert property (
    st_q == S_IDLE && !start_ok |=> !start_q)
    else $error("Conversion started before start-up finished.");
  clamp_a: assert property (
    drdy_q && ovf_q |-> result_q == FS_POS || result_q == FS_NEG)
    else $error("Overload result not clamped to full scale.");

endmodule

/* File: test/acm_conv_model.sv */
// Converter stand-in that answers each start pulse with one raw code.
`timescale 1ns/1ps
module acm_conv_model
  import acm_pkg::*;
#(
  parameter int DELAY = 120
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic [23:0] code,
  output logic             raw_valid,
  output logic [23:0]      raw_code
);
  logic [7:0] cnt_q;

  // Outside a valid pulse the code lines show the inverse of the code.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q     <= 8'h00;
      raw_valid <= 1'b0;
      raw_code  <= 24'h000000;
    end
    else
    begin
      raw_valid <= 1'b0;
      raw_code  <= ~code;
      if (conv_start)
        cnt_q <= 8'(DELAY);
      else if (cnt_q != 8'h00)
      begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          raw_valid <= 1'b1;
          raw_code  <= code;
        end
      end
    end
  end
endmodule

/* File: test/acm_core_tb_top.sv */
// Self-checking bench of the calibration and conversion-mode block.
`timescale 1ns/1ps
module acm_core_tb_top
  import acm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        raw_valid, conv_start, data_ready, overload;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] raw_code, code;
  int          mismatches, checks_done, cyc;

  acm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_valid(raw_valid), .raw_code(raw_code), .conv_start(conv_start),
    .data_ready(data_ready), .overload(overload));

  acm_conv_model conv_u (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .code(code), .raw_valid(raw_valid),
    .raw_code(raw_code));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [3:0] i,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask

  task automatic rd(input logic [3:0] i, output logic [31:0] r);
    logic e;
    apb(1'b0, i, 32'h0, r, e);
  endtask

  function automatic logic [24:0] expv(input logic [23:0] raw, off, g,
                                       input logic oe, ge);
    longint s;
    s = longint'($signed(raw));
    if (oe)
      s = s + longint'($signed(off));
    if (ge)
      s = (s * longint'(g)) >>> 23;
    if (s > 64'sh7fffff)
      return {1'b1, FS_POS};
    if (s < -64'sh800000)
      return {1'b1, FS_NEG};
    return {1'b0, s[23:0]};
  endfunction

  // Starts one run, waits for the result and compares it.
  task automatic conv1(input logic [6:0] cfg, input logic [23:0] c, off,
                       g, input int lo, hi);
    int          n;
    logic [24:0] e;
    logic [31:0] r;
    e = expv(c, off, g, cfg[2], cfg[3]);
    code <= c;
    wr(IDX_CONFIG, {25'h0, cfg});
    n = 0;
    do begin @(posedge pclk); n++; end while (raw_valid !== 1'b1 && n < 3000);
    n = 0;
    do begin @(posedge pclk); n++; end while (data_ready !== 1'b1 && n < 200);
    chk("latency", 32'h1, {31'h0, n >= lo && n <= hi});
    rd(IDX_RESULT, r);
    chk("result", {8'h0, e[23:0]}, r);
    chk("overload", {31'h0, e[24]}, {31'h0, overload});
  endtask

  task automatic state_is(input logic [1:0] s);
    logic [31:0] r;
    rd(IDX_CONFIG, r);
    chk("state", {30'h0, s}, {30'h0, r[5:4]});
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(IDX_CONFIG, r);
    chk("config", {25'h0, CFG_RST}, r);
    rd(IDX_OFFSET, r);
    chk("offset", {8'h0, OFFSET_RST}, r);
    rd(IDX_GAIN, r);
    chk("gain", {8'h0, GAIN_RST}, r);
    rd(IDX_STATUS, r);
    chk("timer", {23'h0, STARTUP_DECIMATION_CLOCK}, {23'h0, r[16:8]});
    wr(IDX_RESULT, 32'h123);
    rd(IDX_RESULT, r);
    chk("result", 32'h0, r);
    apb(1'b0, 4'hf, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask

  task automatic t_offset();
    logic [31:0] r;
    wr(IDX_OFFSET, 32'hfffffb);
    conv1(7'h32, 24'h000100, 24'hfffffb, GAIN_RST, 1, 1);
    state_is(ST_STANDBY);
    wr(IDX_CONFIG, 32'h26);
    rd(IDX_RESULT, r);
    chk("held", 32'h100, r);
    wr(IDX_OFFSET, 32'hfffff0);
    rd(IDX_RESULT, r);
    chk("held", 32'h100, r);
    conv1(7'h36, 24'h000100, 24'hfffff0, GAIN_RST, 1, 1);
    $display("test offset done");
  endtask

  task automatic t_gain();
    logic [31:0] r;
    wr(IDX_GAIN, 32'h400000);
    wr(IDX_OFFSET, 32'h300000);
    rd(IDX_RESULT, r);
    chk("held", 32'h0f0, r);
    conv1(7'h3c, 24'h700000, 24'h300000, 24'h400000, 88, 97);
    state_is(ST_SHUTDOWN);
    rd(IDX_STATUS, r);
    chk("timer", {23'h0, STARTUP_DECIMATION_CLOCK}, {23'h0, r[16:8]});
    $display("test gain done");
  endtask

  task automatic t_clamp();
    wr(IDX_GAIN, 32'hffffff);
    conv1(7'h39, 24'h600000, 24'h300000, 24'hffffff, 88, 97);
    state_is(ST_SHUTDOWN);
    conv1(7'h38, 24'ha00000, 24'h300000, 24'hffffff, 88, 97);
    $display("test clamp done");
  endtask

  task automatic t_cont();
    int n;
    wr(IDX_CONFIG, 32'h3b);
    repeat (3)
    begin
      n = 0;
      do begin @(posedge pclk); n++; end
      while (raw_valid !== 1'b1 && n < 3000);
      @(posedge pclk);
      chk("restart", 32'h1, {31'h0, conv_start});
    end
    state_is(ST_CONVERT);
    wr(IDX_CONFIG, 32'h22);
    repeat (300) @(posedge pclk);
    n = 0;
    repeat (300) begin @(posedge pclk); n += conv_start; end
    chk("stopped", 32'h0, n);
    $display("test continuous done");
  endtask

  task automatic t_scan();
    int n;
    n = 0;
    wr(IDX_CONFIG, 32'h72);
    repeat (2000) begin @(posedge pclk); n += data_ready; end
    chk("scan_count", {29'h0, SCAN_LEN}, n);
    state_is(ST_STANDBY);
    $display("test scan done");
  endtask

  initial
  begin
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code = 24'h000000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_offset();
    t_gain();
    t_clamp();
    t_cont();
    t_scan();
    summarize();
  end
endmodule
